/* File: shared/ofm_pkg.sv */
package ofm_pkg;
    localparam int OFM_NCH = 16;
    localparam int OFM_CLK_MHZ = 40;
    // Blanking uses the least documented time so that faults are seen as early as allowed.
    localparam int OFM_BLANK_US = 100;
    localparam int OFM_BLANK_CYC = OFM_BLANK_US * OFM_CLK_MHZ;
    localparam int OFM_BLANK_W = 12;
    localparam int OFM_FS_US = 450;
    localparam int OFM_FS_CYC = OFM_FS_US * OFM_CLK_MHZ;
    localparam int OFM_STAT_W = 24;
    localparam int OFM_STAT_GLOBAL_BIT = 23;
    localparam int OFM_STAT_OV_BIT = 22;
    localparam logic [15:0] OFM_CFG_RST = 16'h0000;
    localparam logic OFM_RETRY_RST = 1'b0;

    typedef enum logic [1:0] {
        OFM_TH_RUN,
        OFM_TH_HOT,
        OFM_TH_HELD
    } ofm_th_e;
endpackage : ofm_pkg

/* File: shared/ofm_ch_if.sv */
`timescale 1ns/1ps
interface ofm_ch_if;
    logic on_cmd;
    logic sfsd;
    logic retry;
    logic blank_done;
    logic cs_rise;
    logic ol_cmp;
    logic ds_cmp;
    logic hot;
    logic cooled;
    logic ilim;
    logic drive;
    logic latch;
    logic ol_evt;
    logic fault_evt;
    logic glob_evt;

    modport ctl (
        output on_cmd, sfsd, retry, blank_done, cs_rise, ol_cmp, ds_cmp, hot, cooled, ilim,
        input drive, latch, ol_evt, fault_evt, glob_evt
    );
    modport ch (
        input on_cmd, sfsd, retry, blank_done, cs_rise, ol_cmp, ds_cmp, hot, cooled, ilim,
        output drive, latch, ol_evt, fault_evt, glob_evt
    );
endinterface : ofm_ch_if

/* File: logic/ofm_channel.sv */
`timescale 1ns/1ps
module ofm_channel #(
    parameter int FS_CYC = ofm_pkg::OFM_FS_CYC // Fast shutdown delay in cycles.
) (
    input wire logic ref_clk, // Internal clock.
    input wire logic rst, // Device reset, synchronous, active high.
    ofm_ch_if.ch bus // Per-output control and status.
);
    import ofm_pkg::*;

    localparam int CW = $clog2(FS_CYC + 1);

    ofm_th_e th_q, th_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic fsoff_q, fsoff_d;
    logic drive_q, drive_d;
    logic lat_q, lat_d;
    logic ev_fs, ev_th, ev_ilim, ev_ol;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        th_d = th_q;
        cnt_d = '0;
        fsoff_d = fsoff_q;
        ev_fs = 1'b0;
        ev_th = 1'b0;
        if (!bus.on_cmd) begin
            // Apart from reset, commanding the output off is the only way out of a latched-off state.
            th_d = OFM_TH_RUN;
            fsoff_d = 1'b0;
        end else begin
            case (th_q)
                OFM_TH_RUN: begin
                    if (bus.hot) begin
                        th_d = OFM_TH_HOT;
                        ev_th = 1'b1;
                    end
                end
                OFM_TH_HOT: begin
                    if (bus.cooled) begin
                        th_d = bus.retry ? OFM_TH_RUN : OFM_TH_HELD;
                    end
                end
                OFM_TH_HELD: th_d = OFM_TH_HELD;
                default: th_d = OFM_TH_RUN;
            endcase
            if (!bus.sfsd && bus.ds_cmp && !fsoff_q && th_q == OFM_TH_RUN) begin
                if (cnt_q == CW'(FS_CYC - 1)) begin
                    fsoff_d = 1'b1;
                    ev_fs = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
        end
        ev_ol = !bus.on_cmd && bus.blank_done && bus.ol_cmp;
        ev_ilim = bus.on_cmd && bus.ilim;
        drive_d = bus.on_cmd && th_d == OFM_TH_RUN && !fsoff_d;
        // A new event in the clearing cycle wins, so no fault is lost.
        lat_d = ev_ol | ev_fs | ev_th | ev_ilim | (lat_q & ~bus.cs_rise);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            th_q <= OFM_TH_RUN;
            cnt_q <= '0;
            fsoff_q <= 1'b0;
            drive_q <= 1'b0;
            lat_q <= 1'b0;
        end else begin
            th_q <= th_d;
            cnt_q <= cnt_d;
            fsoff_q <= fsoff_d;
            drive_q <= drive_d;
            lat_q <= lat_d;
        end
    end

    assign bus.drive = drive_q;
    assign bus.latch = lat_q;
    assign bus.ol_evt = ev_ol;
    assign bus.fault_evt = ev_ol | ev_fs | ev_th | ev_ilim;
    assign bus.glob_evt = ev_fs | ev_th | ev_ilim;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_fs_trip;
        cnt_q == CW'(FS_CYC - 1) && bus.on_cmd && !bus.sfsd && bus.ds_cmp && !fsoff_q
            && th_q == OFM_TH_RUN;
    endsequence

    sequence s_cool_hold;
        th_q == OFM_TH_HOT && bus.cooled && bus.on_cmd && !bus.retry;
    endsequence

    property p_fs_trip;
        @(posedge ref_clk) disable iff (rst) s_fs_trip |=> !drive_q && lat_q;
    endproperty
    a_fs_trip: assert property (p_fs_trip) else $error("fast shutdown did not trip");

    property p_fs_disabled;
        @(posedge ref_clk) disable iff (rst) bus.sfsd |=> cnt_q == '0;
    endproperty
    a_fs_disabled: assert property (p_fs_disabled) else $error("disabled trip counted");

    property p_hot_off;
        @(posedge ref_clk) disable iff (rst) bus.on_cmd && bus.hot |=> !drive_q && lat_q;
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("hot output still driven");

    property p_cool_hold;
        @(posedge ref_clk) disable iff (rst)
            s_cool_hold ##1 bus.on_cmd |-> th_q == OFM_TH_HELD && !drive_q;
    endproperty
    a_cool_hold: assert property (p_cool_hold) else $error("held output retried");

    property p_cool_retry;
        @(posedge ref_clk) disable iff (rst)
            th_q == OFM_TH_HOT && bus.cooled && bus.on_cmd && bus.retry && !bus.hot
                |=> th_q == OFM_TH_RUN;
    endproperty
    a_cool_retry: assert property (p_cool_retry) else $error("output did not retry");
endmodule : ofm_channel

/* File: logic/ofm_top.sv */
`timescale 1ns/1ps
// How it works
// - Open load checked only while output off.
// - Every output has independent open-load handling.
// - Pull-down off at reset, enabled by controller.
// - Pull-down stays on until sleep, disable or supply undervoltage.
// - Chip-select rise restarts blanking; masks open load.
// - Open-load fault stays latched until read.
// - Drain overvoltage while on trips after delay.
// - Thermal limit turns off only that output.
// - Limit, fast or thermal events set bit 23.
// - Logic supply undervoltage resets outputs and registers.
// - Battery undervoltage turns outputs off, resets.
// - Thermal shutdown leaves other outputs untouched.
// - After cooling, retry or hold per bit 17.
// - Retry bit one retries, zero stays off.
// - Chip-select rise clears all latched faults.
// - Response bits 15..0 carry output faults.
// - Disable bit set leaves only thermal shutdown.
module ofm_top #(
    parameter int NCH = ofm_pkg::OFM_NCH, // Number of outputs.
    parameter int FS_CYC = ofm_pkg::OFM_FS_CYC // Fast shutdown delay in cycles.
) (
    input wire logic ref_clk, // Internal clock, 40 MHz.
    input wire logic rst, // Power-on reset, synchronous, active high.
    input wire logic cs_n, // Chip select from the serial port, active low.
    input wire logic cfg_wr, // One-cycle strobe loading the config words.
    input wire logic [NCH-1:0] cfg_on, // Output command bits.
    input wire logic [NCH-1:0] cfg_pulldown, // Open-load pull-down enables.
    input wire logic [NCH-1:0] cfg_short_fast_shutdown_disable, // Fast shutdown disables.
    input wire logic cfg_thermal_retry, // Global thermal retry bit.
    input wire logic sleep, // Sleep mode request.
    input wire logic logic_supply_pin_uv, // Logic supply undervoltage.
    input wire logic battery_supply_pin_uv, // Battery supply undervoltage.
    input wire logic overvoltage, // Battery overvoltage comparator.
    input wire logic [NCH-1:0] open_load_cmp, // Off-state open-load comparators.
    input wire logic [NCH-1:0] ds_over_cmp, // Drain-source overvoltage comparators.
    input wire logic [NCH-1:0] over_temp, // Thermal limit reached.
    input wire logic [NCH-1:0] cooled, // Cooled past threshold and hysteresis.
    input wire logic [NCH-1:0] cur_limit, // Output in current limit.
    output logic [NCH-1:0] out_drive, // Gate drive per output.
    output logic [NCH-1:0] pulldown_on, // Pull-down source enables.
    output logic [ofm_pkg::OFM_STAT_W-1:0] status_word // Serial response word.
);
    import ofm_pkg::*;

    logic dev_rst;
    logic cs_q, cs_d;
    logic cs_rise;
    logic [OFM_BLANK_W-1:0] blank_q, blank_d;
    logic blank_done;
    logic [NCH-1:0] on_q, on_d;
    logic [NCH-1:0] pd_q, pd_d;
    logic [NCH-1:0] sfsd_q, sfsd_d;
    logic retry_q, retry_d;
    logic glob_q, glob_d;
    logic [OFM_STAT_W-1:0] stat_q, stat_d;
    logic [NCH-1:0] drive_v, lat_v, olev_v, fev_v, gev_v;

    // Either undervoltage drops the whole device back to its power-on state.
    assign dev_rst = rst | logic_supply_pin_uv | battery_supply_pin_uv;

    ////////////////////////////////////////////////////////////////////////////////
    // Blanking timer, restarted by every chip-select rising edge.
    always_comb begin
        cs_d = cs_n;
        cs_rise = cs_n && !cs_q;
        blank_d = blank_q;
        if (cs_rise) begin
            blank_d = '0;
        end else if (blank_q != OFM_BLANK_W'(OFM_BLANK_CYC)) begin
            blank_d = blank_q + 1'b1;
        end
        blank_done = blank_q == OFM_BLANK_W'(OFM_BLANK_CYC) && !cs_rise;
    end

    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            cs_q <= 1'b1;
            blank_q <= '0;
        end else begin
            cs_q <= cs_d;
            blank_q <= blank_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control words.
    always_comb begin
        on_d = on_q;
        pd_d = pd_q;
        sfsd_d = sfsd_q;
        retry_d = retry_q;
        if (cfg_wr) begin
            on_d = cfg_on;
            pd_d = cfg_pulldown;
            sfsd_d = cfg_short_fast_shutdown_disable;
            retry_d = cfg_thermal_retry;
        end
        // Sleep wins over a write in the same cycle, keeping standby current low.
        if (sleep) begin
            pd_d = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            on_q <= NCH'(OFM_CFG_RST);
            pd_q <= NCH'(OFM_CFG_RST);
            sfsd_q <= NCH'(OFM_CFG_RST);
            retry_q <= OFM_RETRY_RST;
        end else begin
            on_q <= on_d;
            pd_q <= pd_d;
            sfsd_q <= sfsd_d;
            retry_q <= retry_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One independent supervisor per output.
    ofm_ch_if chif[NCH]();

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign chif[g].on_cmd = on_q[g];
        assign chif[g].sfsd = sfsd_q[g];
        assign chif[g].retry = retry_q;
        assign chif[g].blank_done = blank_done;
        assign chif[g].cs_rise = cs_rise;
        assign chif[g].ol_cmp = open_load_cmp[g];
        assign chif[g].ds_cmp = ds_over_cmp[g];
        assign chif[g].hot = over_temp[g];
        assign chif[g].cooled = cooled[g];
        assign chif[g].ilim = cur_limit[g];
        assign drive_v[g] = chif[g].drive;
        assign lat_v[g] = chif[g].latch;
        assign olev_v[g] = chif[g].ol_evt;
        assign fev_v[g] = chif[g].fault_evt;
        assign gev_v[g] = chif[g].glob_evt;

        ofm_channel #(
            .FS_CYC(FS_CYC)
        ) u_ch (
            .ref_clk(ref_clk),
            .rst(dev_rst),
            .bus(chif[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Response word. The per-output bits come from the channel latches one cycle late.
    always_comb begin
        glob_d = (|gev_v) | (glob_q & ~cs_rise);
        stat_d = '0;
        stat_d[NCH-1:0] = lat_v;
        stat_d[OFM_STAT_OV_BIT] = overvoltage;
        stat_d[OFM_STAT_GLOBAL_BIT] = glob_q;
    end

    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            glob_q <= 1'b0;
            stat_q <= '0;
        end else begin
            glob_q <= glob_d;
            stat_q <= stat_d;
        end
    end

    assign out_drive = drive_v;
    assign pulldown_on = pd_q;
    assign status_word = stat_q;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_cs_clear;
        cs_rise && fev_v == '0;
    endsequence

    property p_pd_reset;
        @(posedge ref_clk) dev_rst |=> pulldown_on == '0 && out_drive == '0;
    endproperty
    a_pd_reset: assert property (p_pd_reset) else $error("reset left outputs active");

    // A supply dip is a legal way to drop the enables, so cycles in reset start no attempt.
    property p_pd_hold;
        @(posedge ref_clk) disable iff (dev_rst)
            !dev_rst && !sleep && !cfg_wr |=> pulldown_on == $past(pulldown_on);
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("pull-down changed by itself");

    property p_pd_sleep;
        @(posedge ref_clk) disable iff (dev_rst) sleep |=> pulldown_on == '0;
    endproperty
    a_pd_sleep: assert property (p_pd_sleep) else $error("pull-down on in sleep");

    property p_blank_mask;
        @(posedge ref_clk) disable iff (dev_rst)
            cs_rise |-> olev_v == '0 ##1 (olev_v == '0)[*8];
    endproperty
    a_blank_mask: assert property (p_blank_mask) else $error("open load in blanking");

    property p_blank_count;
        @(posedge ref_clk) disable iff (dev_rst) cs_rise |=> blank_q == '0;
    endproperty
    a_blank_count: assert property (p_blank_count) else $error("blanking not restarted");

    property p_ol_off_only;
        @(posedge ref_clk) disable iff (dev_rst) (olev_v & on_q) == '0;
    endproperty
    a_ol_off_only: assert property (p_ol_off_only) else $error("open load while driven");

    property p_cs_clear;
        @(posedge ref_clk) disable iff (dev_rst)
            s_cs_clear |=> lat_v == '0 ##1 stat_q[NCH-1:0] == '0;
    endproperty
    a_cs_clear: assert property (p_cs_clear) else $error("latches survived clear");

    property p_ol_latch;
        @(posedge ref_clk) disable iff (dev_rst)
            olev_v != '0 |=> (lat_v & $past(olev_v)) == $past(olev_v);
    endproperty
    a_ol_latch: assert property (p_ol_latch) else $error("open load not latched");

    property p_stat_map;
        @(posedge ref_clk) disable iff (dev_rst) !dev_rst |=> stat_q[NCH-1:0] == $past(lat_v);
    endproperty
    a_stat_map: assert property (p_stat_map) else $error("status bits misplaced");

    property p_glob;
        @(posedge ref_clk) disable iff (dev_rst)
            gev_v != '0 |=> glob_q ##1 stat_q[OFM_STAT_GLOBAL_BIT];
    endproperty
    a_glob: assert property (p_glob) else $error("global fault bit not set");
endmodule : ofm_top

/* File: sim/ofm_mcu_model.sv */
`timescale 1ns/1ps
// Controller side: loads the config words and frames chip select.
module ofm_mcu_model (
    input wire logic ref_clk, // Internal clock.
    output logic cs_n, // Chip select, active low.
    output logic cfg_wr, // Config load strobe.
    output logic [15:0] cfg_on, // Output commands.
    output logic [15:0] cfg_pulldown, // Pull-down enables.
    output logic [15:0] cfg_sfsd, // Fast shutdown disables.
    output logic cfg_retry // Thermal retry.
);
    initial begin
        cs_n = 1'b1;
        cfg_wr = 1'b0;
        cfg_on = 16'h0000;
        cfg_pulldown = 16'h0000;
        cfg_sfsd = 16'h0000;
        cfg_retry = 1'b0;
    end

    // The pull-down is only on once the controller asks for it.
    task automatic write_cfg(input logic [15:0] on, input logic [15:0] pd,
                             input logic [15:0] sd, input logic rt);
        @(posedge ref_clk);
        cfg_on <= on;
        cfg_pulldown <= pd;
        cfg_sfsd <= sd;
        cfg_retry <= rt;
        cfg_wr <= 1'b1;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
    endtask : write_cfg

    // Returns in the time step of the edge that sees the rise.
    task automatic cs_rise();
        @(posedge ref_clk);
        cs_n <= 1'b0;
        @(posedge ref_clk);
        cs_n <= 1'b1;
        @(posedge ref_clk);
    endtask : cs_rise
endmodule : ofm_mcu_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
    import ofm_pkg::*;
    localparam int FS = 20;
    logic ref_clk, rst, cs_n, cfg_wr, cfg_retry, sleep, lsu, bsu, ovv;
    logic [15:0] cfg_on, cfg_pd, cfg_sd, olc, dsc, otmp, cool, clim, out_drive, pulldown_on;
    logic [23:0] status_word;
    int bad_count = 0;
    int num_checks = 0;

    ofm_mcu_model i_ofm_mcu_model (.ref_clk(ref_clk), .cs_n(cs_n), .cfg_wr(cfg_wr),
        .cfg_on(cfg_on), .cfg_pulldown(cfg_pd), .cfg_sfsd(cfg_sd), .cfg_retry(cfg_retry));

    ofm_top #(.NCH(16), .FS_CYC(FS)) i_ofm_top (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
        .cfg_wr(cfg_wr), .cfg_on(cfg_on), .cfg_pulldown(cfg_pd),
        .cfg_short_fast_shutdown_disable(cfg_sd), .cfg_thermal_retry(cfg_retry),
        .sleep(sleep), .logic_supply_pin_uv(lsu), .battery_supply_pin_uv(bsu),
        .overvoltage(ovv), .open_load_cmp(olc), .ds_over_cmp(dsc), .over_temp(otmp),
        .cooled(cool), .cur_limit(clim), .out_drive(out_drive), .pulldown_on(pulldown_on),
        .status_word(status_word));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_cyc

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // Clears latched faults; set wins, so sources are dropped beforehand.
    task automatic clear_faults();
        i_ofm_mcu_model.cs_rise();
        wait_cyc(3);
    endtask : clear_faults

    task automatic uv_pulse(input logic which);
        @(posedge ref_clk);
        if (which) begin
            lsu <= 1'b1;
        end else begin
            bsu <= 1'b1;
        end
        @(posedge ref_clk);
        lsu <= 1'b0;
        bsu <= 1'b0;
        wait_cyc(2);
    endtask : uv_pulse

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25ns * 60000);
        bad_count++;
        $display("Error watchdog expected done seen hang");
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        {sleep, lsu, bsu, ovv} = 4'h0;
        {olc, dsc, otmp, cool, clim} = {5{16'h0000}};
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        wait_cyc(1);
        check("pulldown after reset", 24'h000000, {8'h00, pulldown_on});
        check("drive after reset", 24'h000000, {8'h00, out_drive});
        check("status after reset", 24'h000000, status_word);
        i_ofm_mcu_model.write_cfg(16'h0001, 16'hFFFF, 16'h0000, 1'b0);
        wait_cyc(2);
        check("pulldown enabled", 24'h00FFFF, {8'h00, pulldown_on});
        wait_cyc(200);
        check("pulldown held", 24'h00FFFF, {8'h00, pulldown_on});
        // Open load on an off output and on an on output at once.
        @(posedge ref_clk);
        olc <= 16'h0003;
        i_ofm_mcu_model.cs_rise();
        wait_cyc(3990);
        check("blanked status", 24'h000000, status_word);
        wait_cyc(20);
        check("open load status", 24'h000002, status_word);
        @(posedge ref_clk);
        olc <= 16'h0000;
        wait_cyc(50);
        check("open load kept", 24'h000002, status_word);
        clear_faults();
        check("cleared status", 24'h000000, status_word);
        @(posedge ref_clk);
        sleep <= 1'b1;
        wait_cyc(3);
        check("pulldown in sleep", 24'h000000, {8'h00, pulldown_on});
        @(posedge ref_clk);
        sleep <= 1'b0;
        // Output 0 trips fast, output 2 relies on thermal only.
        i_ofm_mcu_model.write_cfg(16'h0005, 16'h0000, 16'h0004, 1'b0);
        @(posedge ref_clk);
        dsc <= 16'h0005;
        wait_cyc(FS - 5);
        check("drive before delay", 24'h000005, {8'h00, out_drive});
        wait_cyc(15);
        check("drive after delay", 24'h000004, {8'h00, out_drive});
        check("fast shutdown status", 24'h800001, status_word);
        @(posedge ref_clk);
        dsc <= 16'h0000;
        clear_faults();
        // Thermal with latch-off, then with retry.
        i_ofm_mcu_model.write_cfg(16'h0018, 16'h0000, 16'h0000, 1'b0);
        clear_faults();
        @(posedge ref_clk);
        otmp <= 16'h0008;
        wait_cyc(3);
        check("thermal drive", 24'h000010, {8'h00, out_drive});
        check("thermal status", 24'h800008, status_word);
        @(posedge ref_clk);
        otmp <= 16'h0000;
        cool <= 16'h0008;
        wait_cyc(10);
        check("held after cooling", 24'h000010, {8'h00, out_drive});
        i_ofm_mcu_model.write_cfg(16'h0010, 16'h0000, 16'h0000, 1'b1);
        i_ofm_mcu_model.write_cfg(16'h0018, 16'h0000, 16'h0000, 1'b1);
        @(posedge ref_clk);
        cool <= 16'h0000;
        otmp <= 16'h0008;
        wait_cyc(3);
        check("retry trip", 24'h000010, {8'h00, out_drive});
        @(posedge ref_clk);
        otmp <= 16'h0000;
        cool <= 16'h0008;
        wait_cyc(4);
        check("retry redrive", 24'h000018, {8'h00, out_drive});
        @(posedge ref_clk);
        cool <= 16'h0000;
        clear_faults();
        @(posedge ref_clk);
        clim <= 16'h0010;
        @(posedge ref_clk);
        clim <= 16'h0000;
        wait_cyc(3);
        check("limit status", 24'h800010, status_word);
        clear_faults();
        check("limit cleared", 24'h000000, status_word);
        @(posedge ref_clk);
        ovv <= 1'b1;
        wait_cyc(3);
        check("overvoltage status", 24'h400000, status_word);
        @(posedge ref_clk);
        ovv <= 1'b0;
        // Both supply undervoltages reset the whole device.
        i_ofm_mcu_model.write_cfg(16'hFFFF, 16'hFFFF, 16'h0000, 1'b1);
        uv_pulse(1'b1);
        check("logic uv drive", 24'h000000, {8'h00, out_drive});
        check("logic uv pulldown", 24'h000000, {8'h00, pulldown_on});
        i_ofm_mcu_model.write_cfg(16'h8001, 16'h0000, 16'h0000, 1'b0);
        wait_cyc(2);
        check("drive restored", 24'h008001, {8'h00, out_drive});
        uv_pulse(1'b0);
        check("battery uv drive", 24'h000000, {8'h00, out_drive});
        wrap_up();
    end
endmodule : tb
